// file: multichannel_dma_transfer_engine.sv
`timescale 1ns/10ps
`include "dma_engine_cfg.svh"

module multichannel_dma_transfer_engine
    import dma_engine_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [2:0]  trig,
    output logic             mem_bus_req,
    input  wire logic        mem_grant,
    output logic [15:0]      mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic             mem_byte,
    output logic [15:0]      mem_wdata,
    input  wire logic [15:0] mem_rdata
);

    function automatic word_t step_addr(input word_t a, input logic [1:0] sel,
                                        input logic is_byte);
        word_t inc;
        inc = is_byte ? 16'h0001 : 16'h0002;
        if (sel == `STEP_DOWN)
            step_addr = a - inc;
        else if (sel == `STEP_UP)
            step_addr = a + inc;
        else
            step_addr = a;
    endfunction : step_addr

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        for (int b = 0; b < 4; b++)
            merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    endfunction : merge

    // bus slave state
    logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        awready_q, awready_d, wready_q, wready_d;
    logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic        wr_fire;
    logic        wr_hit;

    // engine state
    logic [10:0] ctl_q [3];
    logic [10:0] ctl_d [3];
    word_t       src_q [3], src_d [3], dst_q [3], dst_d [3], cnt_q [3], cnt_d [3];
    word_t       wsrc_q [3], wsrc_d [3], wdst_q [3], wdst_d [3], save_q [3], save_d [3];
    logic [2:0]  pend_q, pend_d, blk_q, blk_d, flag_q, flag_d, trig_prev_q;
    logic [2:0]  want;
    logic [1:0]  prio_q, prio_d;
    move_state_e st_q, st_d;
    chan_idx_t   act_q, act_d, sel;
    logic [2:0]  burst_q, burst_d;
    logic [1:0]  slot_q, slot_d;
    logic        req_q, req_d, rd_q, rd_d, wrs_q, wrs_d, byte_q, byte_d;
    word_t       addr_q, addr_d, wdat_q, wdat_d;

    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

    // ---------------- bus slave ----------------
    always_comb begin
        logic [7:0] ra;
        ra        = s_axi_araddr;
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        // address and data may arrive in either order
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        if (rvalid_q && s_axi_rready)
            rvalid_d = 1'b0;
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = `RESP_OKAY;
            rdata_d  = 32'h0000_0000;
            if (ra[1:0] != 2'h0 || ra > `STAT_OFS)
                rresp_d = `RESP_SLVERR;
            else if (ra == `PRIO_OFS)
                rdata_d = {30'h0, prio_q};
            else if (ra == `FLAG_OFS)
                rdata_d = {29'h0, flag_q};
            else if (ra == `STAT_OFS)
                rdata_d = {25'h0, blk_q, act_q, st_q};
            else if (ra[3:0] == 4'(`CH_CTL_OFS))
                rdata_d = {21'h0, ctl_q[ra[5:4]]};
            else if (ra[3:0] == 4'(`CH_SRC_OFS))
                rdata_d = {16'h0, src_q[ra[5:4]]};
            else if (ra[3:0] == 4'(`CH_DST_OFS))
                rdata_d = {16'h0, dst_q[ra[5:4]]};
            else
                rdata_d = {16'h0, cnt_q[ra[5:4]]};
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d  = !w_have_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= `RESP_OKAY;
            rdata_q   <= 32'h0000_0000;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
        end
    end

    assign wr_hit = (awaddr_q[1:0] == 2'h0) && (awaddr_q <= `FLAG_OFS);

    // ---------------- engine ----------------
    // a channel wants the bus when enabled, count nonzero and triggered
    always_comb begin
        for (int c = 0; c < 3; c++) begin
            if (!ctl_q[c][`CTL_EN_BIT] || cnt_q[c] == 16'h0000)
                want[c] = 1'b0;
            else if (ctl_q[c][`CTL_LEVEL_BIT])
                want[c] = trig[c];
            else
                want[c] = pend_q[c] || blk_q[c];
        end
        // lowest k wins; prio 0 gives channel 0 first
        sel = 2'h0;
        for (int k = 2; k >= 0; k--) begin
            if (want[(32'(prio_q) + k) % 3])
                sel = chan_idx_t'((32'(prio_q) + k) % 3);
        end
    end

    always_comb begin
        logic [31:0] m;
        logic [2:0]  mode;
        logic        last;
        logic        go_on;
        chan_idx_t   a;
        for (int c = 0; c < 3; c++) begin
            ctl_d[c]  = ctl_q[c];
            src_d[c]  = src_q[c];
            dst_d[c]  = dst_q[c];
            cnt_d[c]  = cnt_q[c];
            wsrc_d[c] = wsrc_q[c];
            wdst_d[c] = wdst_q[c];
            save_d[c] = save_q[c];
        end
        m       = 32'h0000_0000;
        pend_d  = pend_q;
        blk_d   = blk_q;
        flag_d  = flag_q;
        prio_d  = prio_q;
        st_d    = st_q;
        act_d   = act_q;
        burst_d = burst_q;
        slot_d  = slot_q;
        req_d   = req_q;
        rd_d    = 1'b0;
        wrs_d   = 1'b0;
        byte_d  = byte_q;
        addr_d  = addr_q;
        wdat_d  = wdat_q;
        a       = act_q;
        mode    = ctl_q[a][`CTL_MODE_LSB +: 3];
        last    = (cnt_q[a] == 16'h0001);
        go_on   = 1'b0;

        // trigger capture; a running block swallows further edges
        for (int c = 0; c < 3; c++) begin
            if (ctl_q[c][`CTL_EN_BIT] && !ctl_q[c][`CTL_LEVEL_BIT] && !blk_q[c]
                && trig[c] && !trig_prev_q[c])
                pend_d[c] = 1'b1;
        end

        case (st_q)
            ST_IDLE: begin
                req_d   = |want;
                burst_d = 3'h0;
                if (|want && mem_grant) begin
                    st_d   = ST_READ;
                    act_d  = sel;
                    rd_d   = 1'b1;
                    addr_d = wsrc_q[sel];
                    byte_d = ctl_q[sel][`CTL_SBYTE_BIT];
                    pend_d[sel] = 1'b0;
                    if (ctl_q[sel][`CTL_MODE_LSB +: 2] != 2'h0)
                        blk_d[sel] = 1'b1;
                end
            end
            ST_READ: begin
                // memory answers the read in the same cycle as the strobe
                st_d   = ST_WRITE;
                wrs_d  = 1'b1;
                addr_d = wdst_q[a];
                byte_d = ctl_q[a][`CTL_DBYTE_BIT];
                if (ctl_q[a][`CTL_SBYTE_BIT])
                    wdat_d = {8'h00, mem_rdata[7:0]};
                else
                    wdat_d = mem_rdata;
            end
            ST_WRITE: begin
                wsrc_d[a] = step_addr(wsrc_q[a], ctl_q[a][`CTL_SSTEP_LSB +: 2],
                                      ctl_q[a][`CTL_SBYTE_BIT]);
                wdst_d[a] = step_addr(wdst_q[a], ctl_q[a][`CTL_DSTEP_LSB +: 2],
                                      ctl_q[a][`CTL_DBYTE_BIT]);
                burst_d   = burst_q + 3'h1;
                if (last) begin
                    cnt_d[a]  = save_q[a];
                    flag_d[a] = 1'b1;
                    if (!mode[2])
                        ctl_d[a][`CTL_EN_BIT] = 1'b0;
                    // repeated burst restarts by itself, others wait a trigger
                    if (mode[2:1] != 2'h3)
                        blk_d[a] = 1'b0;
                end else begin
                    cnt_d[a] = cnt_q[a] - 16'h0001;
                    go_on = blk_q[a] && mem_grant
                            && (!ctl_q[a][`CTL_LEVEL_BIT] || trig[a]);
                end
                if (mode[1] && burst_q == `BURST_MOVES - 3'h1) begin
                    st_d   = ST_CPU_SLOT;
                    slot_d = `CPU_SLOT_CYCLES - 2'h2;
                    req_d  = 1'b0;
                end else if (go_on) begin
                    st_d   = ST_READ;
                    rd_d   = 1'b1;
                    addr_d = wsrc_d[a];
                    byte_d = ctl_q[a][`CTL_SBYTE_BIT];
                end else begin
                    st_d  = ST_IDLE;
                    req_d = 1'b0;
                end
            end
            ST_CPU_SLOT: begin
                req_d = 1'b0;
                if (slot_q == 2'h0)
                    st_d = ST_IDLE;
                else
                    slot_d = slot_q - 2'h1;
            end
            default: st_d = ST_IDLE;
        endcase

        // software writes; a hardware set of a done flag wins over its clear
        if (wr_fire && wr_hit) begin
            if (awaddr_q == `PRIO_OFS) begin
                m = merge({30'h0, prio_q}, wdata_q, wstrb_q);
                prio_d = (m[1:0] > 2'h2) ? 2'h0 : m[1:0];
            end else if (awaddr_q == `FLAG_OFS) begin
                m = merge(32'h0, wdata_q, wstrb_q);
                flag_d = flag_q & ~m[2:0];
                if (st_q == ST_WRITE && last)
                    flag_d[a] = 1'b1;
            end else begin
                for (int c = 0; c < 3; c++) begin
                    if (awaddr_q[5:4] == 2'(c)) begin
                        if (awaddr_q[3:0] == 4'(`CH_CTL_OFS)) begin
                            m = merge({21'h0, ctl_q[c]}, wdata_q, wstrb_q) & `CTL_MASK;
                            ctl_d[c] = m[10:0];
                            if (m[`CTL_EN_BIT] && !ctl_q[c][`CTL_EN_BIT]) begin
                                wsrc_d[c] = src_q[c];
                                wdst_d[c] = dst_q[c];
                                save_d[c] = cnt_q[c];
                            end
                        end else if (awaddr_q[3:0] == 4'(`CH_SRC_OFS)) begin
                            m = merge({16'h0, src_q[c]}, wdata_q, wstrb_q);
                            src_d[c] = m[15:0];
                        end else if (awaddr_q[3:0] == 4'(`CH_DST_OFS)) begin
                            m = merge({16'h0, dst_q[c]}, wdata_q, wstrb_q);
                            dst_d[c] = m[15:0];
                        end else begin
                            m = merge({16'h0, cnt_q[c]}, wdata_q, wstrb_q);
                            cnt_d[c] = m[15:0];
                        end
                    end
                end
            end
        end

        // a disabled channel forgets pending work
        for (int c = 0; c < 3; c++) begin
            if (!ctl_d[c][`CTL_EN_BIT]) begin
                pend_d[c] = 1'b0;
                blk_d[c]  = 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int c = 0; c < 3; c++) begin
                ctl_q[c]  <= `CTL_RESET;
                src_q[c]  <= `ADDR_RESET;
                dst_q[c]  <= `ADDR_RESET;
                cnt_q[c]  <= `CNT_RESET;
                wsrc_q[c] <= `ADDR_RESET;
                wdst_q[c] <= `ADDR_RESET;
                save_q[c] <= `CNT_RESET;
            end
            pend_q      <= 3'h0;
            blk_q       <= 3'h0;
            flag_q      <= 3'h0;
            trig_prev_q <= 3'h0;
            prio_q      <= `PRIO_RESET;
            st_q        <= ST_IDLE;
            act_q       <= 2'h0;
            burst_q     <= 3'h0;
            slot_q      <= 2'h0;
            req_q       <= 1'b0;
            rd_q        <= 1'b0;
            wrs_q       <= 1'b0;
            byte_q      <= 1'b0;
            addr_q      <= 16'h0000;
            wdat_q      <= 16'h0000;
        end else begin
            for (int c = 0; c < 3; c++) begin
                ctl_q[c]  <= ctl_d[c];
                src_q[c]  <= src_d[c];
                dst_q[c]  <= dst_d[c];
                cnt_q[c]  <= cnt_d[c];
                wsrc_q[c] <= wsrc_d[c];
                wdst_q[c] <= wdst_d[c];
                save_q[c] <= save_d[c];
            end
            pend_q      <= pend_d;
            blk_q       <= blk_d;
            flag_q      <= flag_d;
            trig_prev_q <= trig;
            prio_q      <= prio_d;
            st_q        <= st_d;
            act_q       <= act_d;
            burst_q     <= burst_d;
            slot_q      <= slot_d;
            req_q       <= req_d;
            rd_q        <= rd_d;
            wrs_q       <= wrs_d;
            byte_q      <= byte_d;
            addr_q      <= addr_d;
            wdat_q      <= wdat_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign mem_bus_req   = req_q;
    assign mem_rd        = rd_q;
    assign mem_wr        = wrs_q;
    assign mem_byte      = byte_q;
    assign mem_addr      = addr_q;
    assign mem_wdata     = wdat_q;

endmodule : multichannel_dma_transfer_engine

// file: dma_engine_cfg.svh
`ifndef DMA_ENGINE_CFG_SVH
`define DMA_ENGINE_CFG_SVH

// channel register block: base = channel * stride
`define CH_STRIDE        8'h10
`define CH_CTL_OFS       8'h00
`define CH_SRC_OFS       8'h04
`define CH_DST_OFS       8'h08
`define CH_CNT_OFS       8'h0C
`define PRIO_OFS         8'h30
`define FLAG_OFS         8'h34
`define STAT_OFS         8'h38

// chan_control fields
`define CTL_EN_BIT       0
`define CTL_LEVEL_BIT    1
`define CTL_MODE_LSB     2
`define CTL_SSTEP_LSB    5
`define CTL_DSTEP_LSB    7
`define CTL_SBYTE_BIT    9
`define CTL_DBYTE_BIT    10
`define CTL_MASK         32'h0000_07FF

// step selections: 00/01 hold, 10 down, 11 up
`define STEP_DOWN        2'h2
`define STEP_UP          2'h3

`define CTL_RESET        11'h000
`define ADDR_RESET       16'h0000
`define CNT_RESET        16'h0000
`define PRIO_RESET       2'h0

// burst-block: moves between processor slots and slot length in cycles
`define BURST_MOVES      3'h4
`define CPU_SLOT_CYCLES  2'h2

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// file: dma_engine_pkg.sv
package dma_engine_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_CPU_SLOT
    } move_state_e;

    typedef logic [15:0] word_t;
    typedef logic [1:0]  chan_idx_t;

endpackage : dma_engine_pkg

// file: dma_engine_monitor.sv
`timescale 1ns/10ps
module dma_engine_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        mem_bus_req,
    input wire logic        mem_grant,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic        mem_byte,
    input wire logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rd_wr; mem_rd |=> mem_wr && !mem_rd; endproperty
    a_rd_wr: assert property (p_rd_wr)
        else $error("read cycle not followed by write cycle");
    property p_wr_rd; mem_wr |-> $past(mem_rd) && !mem_rd; endproperty
    a_wr_rd: assert property (p_wr_rd)
        else $error("write cycle without read cycle before it");
    property p_granted; mem_rd |-> $past(mem_grant) && mem_bus_req; endproperty
    a_granted: assert property (p_granted)
        else $error("move started without grant");
    property p_idle; !mem_bus_req |-> !mem_rd && !mem_wr; endproperty
    a_idle: assert property (p_idle)
        else $error("bus cycle while bus not requested");
    property p_hi_zero;
        (mem_rd && mem_byte) ##1 (mem_wr && !mem_byte) |-> mem_wdata[15:8] == 8'h00;
    endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("upper byte not cleared on byte to word");
    property p_word_pass; mem_rd && !mem_byte |=> mem_wdata == $past(mem_rdata); endproperty
    a_word_pass: assert property (p_word_pass)
        else $error("word source data not passed on");
    property p_byte_pass;
        mem_rd && mem_byte |=> mem_wdata[7:0] == $past(mem_rdata[7:0]);
    endproperty
    a_byte_pass: assert property (p_byte_pass)
        else $error("byte source data not passed on");
    property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("register read not answered next cycle");
endmodule : dma_engine_monitor

bind multichannel_dma_transfer_engine dma_engine_monitor dma_engine_monitor_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .mem_bus_req(mem_bus_req), .mem_grant(mem_grant), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_byte(mem_byte), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));

// file: mem_partner.sv
`timescale 1ns/10ps
module mem_partner (
    input  wire logic        aclk,
    input  wire logic        grant_en,
    output logic             mem_grant,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic        mem_byte,
    input  wire logic [15:0] mem_wdata,
    output logic [15:0]      mem_rdata
);
    logic [7:0]  mem [0:255];
    logic [7:0]  lo_a;
    logic [7:0]  hi_a;
    logic [15:0] rd_val;
    logic [15:0] last_q = 16'h0000;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    assign mem_grant = grant_en;
    assign lo_a = mem_byte ? mem_addr[7:0] : {mem_addr[7:1], 1'b0};
    assign hi_a = {mem_addr[7:1], 1'b1};
    // byte reads carry junk above the byte, so nothing may lean on it
    assign rd_val = mem_byte ? {8'h5A, mem[lo_a]} : {mem[hi_a], mem[lo_a]};
    // a released bus does not keep the last value
    assign mem_rdata = mem_rd ? rd_val : ~last_q;
    always @(posedge aclk) begin
        if (mem_rd) last_q <= rd_val;
        if (mem_wr) begin
            mem[lo_a] <= mem_wdata[7:0];
            if (!mem_byte) mem[hi_a] <= mem_wdata[15:8];
        end
    end
endmodule : mem_partner

// file: multichannel_dma_transfer_engine_tb.sv
`timescale 1ns/10ps
module multichannel_dma_transfer_engine_tb;
    logic aclk = 1'b0, aresetn = 1'b0, grant_en = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [2:0] trig = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, mem_bus_req, mem_grant;
    logic mem_rd, mem_wr, mem_byte;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] mem_addr, mem_wdata, mem_rdata;
    int n_errors = 0, n_compared = 0, n_moves = 0, cyc = 0, q;
    int rd_t[$];
    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (mem_wr === 1'b1) n_moves++;
        if (mem_rd === 1'b1) rd_t.push_back(cyc);
    end
    // responses are always accepted, so the ready lines stay high
    multichannel_dma_transfer_engine multichannel_dma_transfer_engine_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .trig(trig),
        .mem_bus_req(mem_bus_req), .mem_grant(mem_grant), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_byte(mem_byte), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata));
    mem_partner mem_partner_i (
        .aclk(aclk), .grant_en(grant_en), .mem_grant(mem_grant), .mem_addr(mem_addr),
        .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_byte(mem_byte), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata));
    task automatic close_out;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        bit aw, w;
        aw = 0;
        w = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (!aw && awready === 1'b1) begin
                awvalid <= 1'b0;
                aw = 1;
            end
            if (!w && wready === 1'b1) begin
                wvalid <= 1'b0;
                w = 1;
            end
        end while (!(aw && w));
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask : wr
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er = 2'h0);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        chk(nm, e, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask : rd
    task automatic fire(input int c, input int n);
        int t;
        t = 0;
        trig[c] <= 1'b1;
        @(posedge aclk);
        trig[c] <= 1'b0;
        while (n_moves < n && t < 300) begin
            @(posedge aclk);
            t++;
        end
        repeat (10) @(posedge aclk);
    endtask : fire
    function automatic logic [31:0] memw(input logic [7:0] a);
        return {16'h0, mem_partner_i.mem[a + 8'h01], mem_partner_i.mem[a]};
    endfunction : memw
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd("ctl0 reset", 8'h00, 32'h0);
        wr(8'h30, 32'h3);
        rd("prio", 8'h30, 32'h0);
        rd("unmapped", 8'h3C, 32'h0, 2'h2);
        wr(8'h38, 32'h1, 2'h2);
        {mem_partner_i.mem[8'h11], mem_partner_i.mem[8'h10]} = 16'h1234;
        {mem_partner_i.mem[8'h13], mem_partner_i.mem[8'h12]} = 16'hBEEF;
        wr(8'h04, 32'h10);
        wr(8'h08, 32'h40);
        wr(8'h0C, 32'h2);
        wr(8'h00, 32'h1E1);
        grant_en <= 1'b0;
        fire(0, 0);
        chk("moves no grant", 32'd0, n_moves);
        grant_en <= 1'b1;
        fire(0, 0);
        chk("moves one trig", 32'd1, n_moves);
        rd("count", 8'h0C, 32'h1);
        fire(0, 2);
        rd("count reload", 8'h0C, 32'h2);
        rd("flag", 8'h34, 32'h1);
        rd("ctl0 done", 8'h00, 32'h1E0);
        chk("dst0", 32'h1234, memw(8'h40));
        chk("dst1", 32'hBEEF, memw(8'h42));
        fire(0, 3);
        chk("moves disabled", 32'd2, n_moves);
        wr(8'h0C, 32'h0);
        wr(8'h00, 32'h1E1);
        fire(0, 3);
        chk("moves zero count", 32'd2, n_moves);
        wr(8'h34, 32'h7);
        rd("flag clear", 8'h34, 32'h0);
        for (int i = 0; i < 3; i++) mem_partner_i.mem[8'h20 + i] = 8'h11 * (i + 1);
        wr(8'h14, 32'h20);
        wr(8'h18, 32'h8C);
        wr(8'h1C, 32'h3);
        wr(8'h10, 32'h365);
        trig[1] <= 1'b1;
        @(posedge aclk);
        trig[1] <= 1'b0;
        repeat (3) @(posedge aclk);
        fire(1, 5);
        chk("block moves", 32'd5, n_moves);
        for (int i = 0; i < 3; i++) chk("dst word", 32'h11 * (i + 1), memw(8'h8C - 2 * i));
        rd("ctl1 done", 8'h10, 32'h364);
        mem_partner_i.mem[8'h30] = 8'hAB;
        mem_partner_i.mem[8'h31] = 8'hCD;
        wr(8'h24, 32'h30);
        wr(8'h28, 32'hA0);
        wr(8'h2C, 32'h5);
        wr(8'h20, 32'h589);
        q = rd_t.size();
        fire(2, 10);
        chk("moves burst", 32'd10, n_moves);
        chk("back to back", 32'd2, rd_t[q + 1] - rd_t[q]);
        chk("cpu slot", 32'd4, rd_t[q + 4] - rd_t[q + 3]);
        for (int i = 0; i < 6; i++) chk("dst byte", i < 5 ? 8'hAB : 8'h00,
                                        mem_partner_i.mem[8'hA0 + i]);
        rd("flags", 8'h34, 32'h6);
        rd("count2", 8'h2C, 32'h5);
        rd("ctl2 done", 8'h20, 32'h588);
        // both channels hit one fixed word, so the later move shows the order
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h60);
        wr(8'h0C, 32'h1);
        wr(8'h14, 32'h12);
        wr(8'h18, 32'h60);
        wr(8'h30, 32'h1);
        rd("prio1", 8'h30, 32'h1);
        wr(8'h00, 32'h11);
        wr(8'h10, 32'h11);
        trig <= 3'h3;
        @(posedge aclk);
        trig <= 3'h0;
        repeat (12) @(posedge aclk);
        chk("prio order", 32'h1234, memw(8'h60));
        rd("ctl0 repeat", 8'h00, 32'h11);
        close_out();
    end
endmodule : multichannel_dma_transfer_engine_tb
